// [iopc_consts.vh]
`ifndef IOPC_CONSTS_VH
`define IOPC_CONSTS_VH

// ==========================================================
// pin set and function map
// ==========================================================
// pin order: 0..2 port D bits 4..6, 3..6 port E bits 0..3, 7..14 port F bits 0..7
`define IOPC_NPIN 15
`define IOPC_NSEL 8
`define IOPC_SELW 3
`define IOPC_DRVW 3
`define IOPC_GPIO_SEL 3'h0
// one byte per pin, bit s set where setting s carries a function
`define IOPC_SLOT_USED 120'hE7F7B7F7FFFFFFFF6FFFFFFFFFFFFF
// pins that can be routed to the converter
`define IOPC_ANA_MASK 15'h7800
`define IOPC_ANA_LO 11
`define IOPC_NADC 4

// ==========================================================
// register offsets (byte addresses)
// ==========================================================
`define IOPC_AW 8
`define IOPC_OFS_OUTVAL 8'h00
`define IOPC_OFS_OUTEN 8'h04
`define IOPC_OFS_ODEN 8'h08
`define IOPC_OFS_PUEN 8'h0C
`define IOPC_OFS_PDEN 8'h10
`define IOPC_OFS_DBEN 8'h14
`define IOPC_OFS_INVAL 8'h18
`define IOPC_OFS_INTEDGE 8'h1C
`define IOPC_OFS_INTRISE 8'h20
`define IOPC_OFS_INTFALL 8'h24
`define IOPC_OFS_INTFLAG 8'h28
`define IOPC_OFS_INTMASK 8'h2C
`define IOPC_OFS_ANAEN 8'h30
`define IOPC_OFS_MUX0 8'h34
`define IOPC_OFS_MUX1 8'h38
`define IOPC_OFS_DRV0 8'h3C
`define IOPC_OFS_DRV1 8'h40

// ==========================================================
// field layout and reset values
// ==========================================================
`define IOPC_PINS_PER_WORD 8
`define IOPC_NIBBLE 4
`define IOPC_RST_PINS 15'h0000
`define IOPC_RST_SEL 45'h000000000000
`define IOPC_RST_DRV 45'h000000000000
`define IOPC_RST_WORD 32'h00000000
`define IOPC_HTRANS_NONSEQ_BIT 1
`define IOPC_HRESP_OKAY 1'b0

// ==========================================================
// de-bounce filter
// ==========================================================
`define IOPC_DB_CW 3
`define IOPC_DB_STABLE 3'h4

`endif

// [iopc_debounce.v]
`timescale 1ns/1ns
`include "iopc_consts.vh"

// ==========================================================
// per-pin stability filter
// ==========================================================
module iopc_debounce #(
   parameter CW = `IOPC_DB_CW,
   parameter [CW-1:0] STABLE = `IOPC_DB_STABLE
)(
   input wire core_clk,
   input wire rst,
   input wire en,
   input wire din,
   output wire dout
);
   reg [CW-1:0] cnt_r;
   reg out_r;
   localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};
   localparam [CW-1:0] ZERO = {CW{1'b0}};

   assign dout = out_r;

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_r <= ZERO;
         out_r <= 1'b0;
      end
      else if (!en)
      begin
         // bypass: follow the synchronised level directly
         cnt_r <= ZERO;
         out_r <= din;
      end
      else if (din == out_r)
      begin
         cnt_r <= ZERO;
      end
      else if (cnt_r == STABLE - ONE)
      begin
         // new level held long enough
         cnt_r <= ZERO;
         out_r <= din;
      end
      else
      begin
         cnt_r <= cnt_r + ONE;
      end
   end
endmodule

// [iopc_pin_ctrl.v]
// Operation
// - each pin is push-pull output, open-drain output or high-impedance input
// - each pin has separately enabled weak pull-up and pull-down
// - each pin has its own switchable input de-bounce filter
// - each pin's interrupt is level or edge sensitive, chosen per pin
// - edge mode selects rising, falling or both edges
// - per-pin interrupt flag set by events, per-pin enable gates request
// - per-pin drive-strength select among current levels up to 24mA
// - eight-way function select per pin, setting zero is general IO
// - analog input routes pin to converter, bypassing the function select
// - only upper four port F pins support analog, channels four to seven
// - select value decoded by the fixed per-pin function map
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "iopc_consts.vh"

module iopc_pin_ctrl #(
   parameter NPIN = `IOPC_NPIN
)(
   input wire core_clk,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output reg [31:0] hrdata,
   output wire hresp,
   input wire [NPIN-1:0] padIn,
   output reg [NPIN-1:0] padOut,
   output reg [NPIN-1:0] padOe,
   output reg [NPIN-1:0] padPullUp,
   output reg [NPIN-1:0] padPullDown,
   output reg [NPIN*`IOPC_DRVW-1:0] padDrive,
   input wire [NPIN*`IOPC_NSEL-1:0] perOut,
   input wire [NPIN*`IOPC_NSEL-1:0] perOe,
   output reg [NPIN*`IOPC_NSEL-1:0] perIn,
   output reg [`IOPC_NADC-1:0] adcRoute,
   output wire irq
);
   localparam SW = `IOPC_SELW;
   localparam DW = `IOPC_DRVW;
   localparam NS = `IOPC_NSEL;
   localparam [NPIN*NS-1:0] SLOT_USED = `IOPC_SLOT_USED;
   localparam [NPIN-1:0] ANA_MASK = `IOPC_ANA_MASK;
   localparam [NPIN-1:0] ZP = `IOPC_RST_PINS;

   // ==========================================================
   // configuration registers
   // ==========================================================
   reg [NPIN-1:0] outVal_r;
   reg [NPIN-1:0] outEn_r;
   reg [NPIN-1:0] openDrain_r;
   reg [NPIN-1:0] pullUp_r;
   reg [NPIN-1:0] pullDown_r;
   reg [NPIN-1:0] dbEn_r;
   reg [NPIN-1:0] intEdge_r;
   reg [NPIN-1:0] intRise_r;
   reg [NPIN-1:0] intFall_r;
   reg [NPIN-1:0] intFlag_r;
   reg [NPIN-1:0] intMask_r;
   reg [NPIN-1:0] anaEn_r;
   reg [NPIN*SW-1:0] muxSel_r;
   reg [NPIN*DW-1:0] drive_r;

   // ==========================================================
   // bus slave
   // ==========================================================
   reg wrPend_r;
   reg rdPend_r;
   reg [`IOPC_AW-1:0] addr_r;
   reg [31:0] rdVal;
   reg [NPIN-1:0] intFlag_nxt;
   wire accept;
   wire rdFlag;
   integer i, j, k;

   assign accept = hsel & htrans[`IOPC_HTRANS_NONSEQ_BIT] & hready;
   // reads take one wait state so a read right after a write sees it
   assign hreadyout = ~rdPend_r;
   assign hresp = `IOPC_HRESP_OKAY;
   assign rdFlag = rdPend_r & (addr_r == `IOPC_OFS_INTFLAG);

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wrPend_r <= 1'b0;
         rdPend_r <= 1'b0;
         addr_r <= {`IOPC_AW{1'b0}};
         hrdata <= `IOPC_RST_WORD;
      end
      else
      begin
         if (accept)
         begin
            wrPend_r <= hwrite;
            rdPend_r <= ~hwrite;
            addr_r <= {haddr[`IOPC_AW-1:2], 2'b00};
         end
         else
         begin
            wrPend_r <= 1'b0;
            rdPend_r <= 1'b0;
         end
         if (rdPend_r)
         begin
            hrdata <= rdVal;
         end
      end
   end

   // ==========================================================
   // input synchroniser, filter and event detection
   // ==========================================================
   reg [NPIN-1:0] sync1_r;
   reg [NPIN-1:0] sync2_r;
   reg [NPIN-1:0] filtPrev_r;
   wire [NPIN-1:0] filt;
   wire [NPIN-1:0] evt;

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_r <= ZP;
         sync2_r <= ZP;
         filtPrev_r <= ZP;
      end
      else
      begin
         sync1_r <= padIn;
         sync2_r <= sync1_r;
         filtPrev_r <= filt;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1)
      begin : pin
         wire rise;
         wire fall;
         iopc_debounce #(
            .CW(`IOPC_DB_CW),
            .STABLE(`IOPC_DB_STABLE)
         ) u_db (
            .core_clk(core_clk),
            .rst(rst),
            .en(dbEn_r[g]),
            .din(sync2_r[g]),
            .dout(filt[g])
         );
         assign rise = filt[g] & ~filtPrev_r[g];
         assign fall = ~filt[g] & filtPrev_r[g];
         // edge: chosen edges; level: rise bit picks the active level
         assign evt[g] = anaEn_r[g] ? 1'b0 :
            intEdge_r[g] ? ((intRise_r[g] & rise) | (intFall_r[g] & fall)) :
            (filt[g] == intRise_r[g]);
      end
   endgenerate

   // ==========================================================
   // interrupt flags and request
   // ==========================================================
   always @*
   begin
      // a new event in the clearing cycle keeps the flag set
      intFlag_nxt = (intFlag_r & ~(rdFlag ? {NPIN{1'b1}} : ZP)) | evt;
   end

   assign irq = |(intFlag_r & intMask_r);

   // ==========================================================
   // register writes
   // ==========================================================
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         outVal_r <= ZP;
         outEn_r <= ZP;
         openDrain_r <= ZP;
         pullUp_r <= ZP;
         pullDown_r <= ZP;
         dbEn_r <= ZP;
         intEdge_r <= ZP;
         intRise_r <= ZP;
         intFall_r <= ZP;
         intFlag_r <= ZP;
         intMask_r <= ZP;
         anaEn_r <= ZP;
         muxSel_r <= `IOPC_RST_SEL;
         drive_r <= `IOPC_RST_DRV;
      end
      else
      begin
         intFlag_r <= intFlag_nxt;
         if (wrPend_r)
         begin
            case (addr_r)
               `IOPC_OFS_OUTVAL: outVal_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_OUTEN: outEn_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_ODEN: openDrain_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_PUEN: pullUp_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_PDEN: pullDown_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_DBEN: dbEn_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_INTEDGE: intEdge_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_INTRISE: intRise_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_INTFALL: intFall_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_INTMASK: intMask_r <= hwdata[NPIN-1:0];
               `IOPC_OFS_ANAEN: anaEn_r <= hwdata[NPIN-1:0] & ANA_MASK;
               default:
               begin
               end
            endcase
            for (i = 0; i < NPIN; i = i + 1)
            begin
               if (addr_r == ((i < `IOPC_PINS_PER_WORD) ? `IOPC_OFS_MUX0 : `IOPC_OFS_MUX1))
               begin
                  muxSel_r[i*SW +: SW] <=
                     hwdata[(i % `IOPC_PINS_PER_WORD)*`IOPC_NIBBLE +: SW];
               end
               if (addr_r == ((i < `IOPC_PINS_PER_WORD) ? `IOPC_OFS_DRV0 : `IOPC_OFS_DRV1))
               begin
                  drive_r[i*DW +: DW] <=
                     hwdata[(i % `IOPC_PINS_PER_WORD)*`IOPC_NIBBLE +: DW];
               end
            end
         end
      end
   end

   // ==========================================================
   // register reads
   // ==========================================================
   always @*
   begin
      rdVal = `IOPC_RST_WORD;
      case (addr_r)
         `IOPC_OFS_OUTVAL: rdVal[NPIN-1:0] = outVal_r;
         `IOPC_OFS_OUTEN: rdVal[NPIN-1:0] = outEn_r;
         `IOPC_OFS_ODEN: rdVal[NPIN-1:0] = openDrain_r;
         `IOPC_OFS_PUEN: rdVal[NPIN-1:0] = pullUp_r;
         `IOPC_OFS_PDEN: rdVal[NPIN-1:0] = pullDown_r;
         `IOPC_OFS_DBEN: rdVal[NPIN-1:0] = dbEn_r;
         `IOPC_OFS_INVAL: rdVal[NPIN-1:0] = filt;
         `IOPC_OFS_INTEDGE: rdVal[NPIN-1:0] = intEdge_r;
         `IOPC_OFS_INTRISE: rdVal[NPIN-1:0] = intRise_r;
         `IOPC_OFS_INTFALL: rdVal[NPIN-1:0] = intFall_r;
         `IOPC_OFS_INTFLAG: rdVal[NPIN-1:0] = intFlag_r;
         `IOPC_OFS_INTMASK: rdVal[NPIN-1:0] = intMask_r;
         `IOPC_OFS_ANAEN: rdVal[NPIN-1:0] = anaEn_r;
         default:
         begin
         end
      endcase
      for (j = 0; j < NPIN; j = j + 1)
      begin
         if (addr_r == ((j < `IOPC_PINS_PER_WORD) ? `IOPC_OFS_MUX0 : `IOPC_OFS_MUX1))
         begin
            rdVal[(j % `IOPC_PINS_PER_WORD)*`IOPC_NIBBLE +: SW] = muxSel_r[j*SW +: SW];
         end
         if (addr_r == ((j < `IOPC_PINS_PER_WORD) ? `IOPC_OFS_DRV0 : `IOPC_OFS_DRV1))
         begin
            rdVal[(j % `IOPC_PINS_PER_WORD)*`IOPC_NIBBLE +: DW] = drive_r[j*DW +: DW];
         end
      end
   end

   // ==========================================================
   // pad and function multiplexer
   // ==========================================================
   reg [NPIN-1:0] padOut_nxt;
   reg [NPIN-1:0] padOe_nxt;
   reg [NPIN*NS-1:0] perIn_nxt;
   reg [SW-1:0] sel;
   reg slotOk;
   reg srcVal;
   reg srcEn;

   always @*
   begin
      padOut_nxt = ZP;
      padOe_nxt = ZP;
      perIn_nxt = {NPIN*NS{1'b0}};
      sel = `IOPC_GPIO_SEL;
      slotOk = 1'b0;
      srcVal = 1'b0;
      srcEn = 1'b0;
      for (k = 0; k < NPIN; k = k + 1)
      begin
         sel = muxSel_r[k*SW +: SW];
         slotOk = SLOT_USED[k*NS + sel];
         if (sel == `IOPC_GPIO_SEL)
         begin
            srcVal = outVal_r[k];
            srcEn = outEn_r[k];
         end
         else
         begin
            srcVal = perOut[k*NS + sel] & slotOk;
            srcEn = perOe[k*NS + sel] & slotOk;
         end
         if (anaEn_r[k])
         begin
            // analog pin: no digital drive, no digital function
            padOe_nxt[k] = 1'b0;
         end
         else
         begin
            if (openDrain_r[k])
            begin
               padOut_nxt[k] = 1'b0;
               padOe_nxt[k] = srcEn & ~srcVal;
            end
            else
            begin
               padOut_nxt[k] = srcVal;
               padOe_nxt[k] = srcEn;
            end
            perIn_nxt[k*NS + sel] = filt[k] & slotOk;
         end
      end
   end

   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         padOut <= ZP;
         padOe <= ZP;
         padPullUp <= ZP;
         padPullDown <= ZP;
         padDrive <= `IOPC_RST_DRV;
         perIn <= {NPIN*NS{1'b0}};
         adcRoute <= {`IOPC_NADC{1'b0}};
      end
      else
      begin
         padOut <= padOut_nxt;
         padOe <= padOe_nxt;
         // conflicting pulls are passed on as written
         padPullUp <= pullUp_r;
         padPullDown <= pullDown_r;
         padDrive <= drive_r;
         perIn <= perIn_nxt;
         adcRoute <= anaEn_r[`IOPC_ANA_LO +: `IOPC_NADC];
      end
   end
endmodule

// [iopc_props.sv]
`timescale 1ns/1ns
// ==========================================================
// port-level checks of the pin controller
// ==========================================================
module iopc_props #(
   parameter NPIN = 15
)(
   input logic core_clk,
   input logic rst,
   input logic hsel,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic hreadyout,
   input logic [31:0] hrdata,
   input logic [NPIN-1:0] padOe,
   input logic [NPIN-1:0] padPullUp,
   input logic [NPIN-1:0] padPullDown,
   input logic [NPIN*3-1:0] padDrive,
   input logic [NPIN*8-1:0] perIn,
   input logic [3:0] adcRoute,
   input logic irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic taken;
   logic wrSeen_r;
   logic perBad;
   assign taken = hsel & htrans[1] & hready;
   // no write yet: every bus-written register still at reset state
   always @(posedge core_clk or posedge rst)
      if (rst)
         wrSeen_r <= 1'b0;
      else if (taken & hwrite)
         wrSeen_r <= 1'b1;
   always_comb
   begin
      perBad = 1'b0;
      for (int i = 0; i < NPIN; i++)
         if (!$onehot0(perIn[i*8+:8]))
            perBad = 1'b1;
   end
   a_reset_quiet: assert property (!wrSeen_r |-> (padOe | padPullUp | padPullDown) == 0)
      else $error("pad config active before any write");
   a_drive_default: assert property (!wrSeen_r |-> padDrive == 0)
      else $error("drive code not at reset value");
   a_irq_masked: assert property (!wrSeen_r |-> !irq)
      else $error("interrupt with mask at reset value");
   a_analog_no_drive: assert property ((adcRoute & $past(adcRoute) & padOe[14:11]) == 4'h0)
      else $error("analog pin still driven");
   a_analog_no_per: assert property (($past(adcRoute) & adcRoute & {|perIn[119:112],
      |perIn[111:104], |perIn[103:96], |perIn[95:88]}) == 4'h0)
      else $error("analog pin reaches a peripheral");
   a_per_onehot: assert property (!perBad)
      else $error("pin level given to two settings");
   a_irq_holds: assert property ($fell(irq) |-> $past(taken, 2))
      else $error("interrupt dropped without a bus access");
   a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not two cycles");
   a_rdata_holds: assert property (hreadyout |=> $stable(hrdata))
      else $error("read data changed outside a read");
endmodule

// [iopc_board_model.sv]
`timescale 1ns/1ns
// ==========================================================
// board side: resolves each pad from all drivers
// ==========================================================
module iopc_board_model #(
   parameter N = 15
)(
   input wire logic core_clk,
   input wire logic [N-1:0] padOut,
   input wire logic [N-1:0] padOe,
   input wire logic [N-1:0] padPullUp,
   input wire logic [N-1:0] padPullDown,
   input wire logic [N-1:0] extDrv,
   input wire logic [N-1:0] extEn,
   output logic [N-1:0] padIn
);
   logic [N-1:0] lastLvl = 15'h0000;
   always @(posedge core_clk)
      lastLvl <= padIn;
   // floating pads toggle, no stale level
   always_comb
   begin
      for (int i = 0; i < N; i++)
         padIn[i] = padOe[i] ? padOut[i] : extEn[i] ? extDrv[i] :
            padPullUp[i] ? 1'b1 : padPullDown[i] ? 1'b0 : ~lastLvl[i];
   end
endmodule

// [io_pin_controller_with_mux_bench.sv]
`timescale 1ns/1ns
`include "iopc_consts.vh"
module io_pin_controller_with_mux_bench;
   localparam int N = `IOPC_NPIN;
   localparam logic [119:0] SLOT = `IOPC_SLOT_USED;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic hreadyout, hresp, irq;
   logic [31:0] hrdata;
   logic [N-1:0] padIn, padOut, padOe, padPullUp, padPullDown;
   logic [N-1:0] extDrv = 15'h0000;
   logic [N-1:0] extEn = 15'h0000;
   logic [N*3-1:0] padDrive;
   logic [N*8-1:0] perOut = 120'h0, perOe = 120'h0, perIn;
   logic [3:0] adcRoute;
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 32'h57AD;
   always #20 core_clk = ~core_clk;
   iopc_pin_ctrl #(.NPIN(N)) iopc_pin_ctrl_inst (.core_clk, .rst, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .padIn,
      .padOut, .padOe, .padPullUp, .padPullDown, .padDrive, .perOut, .perOe, .perIn,
      .adcRoute, .irq);
   iopc_board_model #(.N(N)) iopc_board_model_inst (.core_clk, .padOut, .padOe,
      .padPullUp, .padPullDown, .extDrv, .extEn, .padIn);
   task automatic end_sim;
   begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
   begin
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task automatic waitRdy;
      int n;
   begin
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         mismatches++;
         end_sim;
      end
   end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
   begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      waitRdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy;
      q = hrdata;
   end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
   begin
      bus(1'b1, a, d, q);
   end
   endtask
   task automatic pin0(input logic b, input int n);
   begin
      extDrv[0] <= b;
      repeat (n) @(posedge core_clk);
   end
   endtask
   function automatic logic [2:0] nib(input logic [63:0] w, input int i);
      return i < 8 ? w[i*4+:3] : w[32+(i-8)*4+:3];
   endfunction
   initial
   begin
      logic [31:0] q, v, e, o, u, dl, m0, m1;
      logic [127:0] r1, r2;
      logic [N-1:0] po, pe;
      logic [N*8-1:0] pi;
      logic [N*3-1:0] pd;
      int k;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (int a = 0; a < 8'h4C; a += 4)
      begin
         bus(1'b0, a[7:0], 32'h0, q);
         if (a != 8'h18 && a != 8'h28)
            chk(q, 32'h0);
         chk(hresp, `IOPC_HRESP_OKAY);
      end
      wr(`IOPC_OFS_PUEN, 32'h7FFF);
      repeat (4)
      begin
         v = $random(seed) & 32'h7FFF;
         e = $random(seed) & 32'h7FFF;
         o = $random(seed) & 32'h7FFF;
         wr(`IOPC_OFS_OUTVAL, v);
         wr(`IOPC_OFS_OUTEN, e);
         wr(`IOPC_OFS_ODEN, o);
         repeat (4) @(posedge core_clk);
         chk(padOe, e & (~o | ~v));
         chk(padOut, v & ~o);
         bus(1'b0, `IOPC_OFS_INVAL, 32'h0, q);
         chk(q, ((e & v) | ~e) & 32'h7FFF);
      end
      wr(`IOPC_OFS_ODEN, 32'h0);
      for (int t = 0; t < 9; t++)
      begin
         r1 = {$random(seed), $random(seed), $random(seed), $random(seed)};
         r2 = {$random(seed), $random(seed), $random(seed), $random(seed)};
         m0 = t < 8 ? 32'h11111111 * t : r1[31:0] & 32'h77777777;
         m1 = t < 8 ? 32'h01111111 * t : r2[31:0] & 32'h07777777;
         perOut <= r1[119:0];
         perOe <= r2[119:0];
         wr(`IOPC_OFS_MUX0, m0);
         wr(`IOPC_OFS_MUX1, m1);
         repeat (8) @(posedge core_clk);
         pi = 120'h0;
         for (int i = 0; i < N; i++)
         begin
            k = i * 8 + nib({m1, m0}, i);
            po[i] = k % 8 == 0 ? v[i] : SLOT[k] & r1[k];
            pe[i] = k % 8 == 0 ? e[i] : SLOT[k] & r2[k];
            pi[k] = SLOT[k] & (pe[i] ? po[i] : 1'b1);
         end
         chk(padOut, po);
         chk(padOe, pe);
         chk(perIn, pi);
      end
      wr(`IOPC_OFS_OUTEN, 32'h7FFF);
      wr(`IOPC_OFS_ANAEN, 32'hFFFFFFFF);
      bus(1'b0, `IOPC_OFS_ANAEN, 32'h0, q);
      chk(q, 32'h7800);
      repeat (4) @(posedge core_clk);
      chk(adcRoute, 4'hF);
      chk(padOe[14:11], 4'h0);
      chk(perIn[119:88], 32'h0);
      wr(`IOPC_OFS_ANAEN, 32'h0);
      wr(`IOPC_OFS_MUX0, 32'h0);
      wr(`IOPC_OFS_MUX1, 32'h0);
      wr(`IOPC_OFS_OUTEN, 32'h0);
      extEn <= 15'h0001;
      wr(`IOPC_OFS_INTEDGE, 32'h7FFF);
      wr(`IOPC_OFS_INTMASK, 32'h1);
      for (int m = 1; m < 4; m++)
      begin
         wr(`IOPC_OFS_INTRISE, m & 1);
         wr(`IOPC_OFS_INTFALL, m >> 1);
         bus(1'b0, `IOPC_OFS_INTFLAG, 32'h0, q);
         pin0(1'b1, 8);
         chk(irq, m & 1);
         bus(1'b0, `IOPC_OFS_INTFLAG, 32'h0, q);
         chk(q & 1, m & 1);
         chk(irq, 1'b0);
         pin0(1'b0, 8);
         bus(1'b0, `IOPC_OFS_INTFLAG, 32'h0, q);
         chk(q & 1, m >> 1);
      end
      wr(`IOPC_OFS_INTEDGE, 32'h0);
      wr(`IOPC_OFS_INTRISE, 32'h1);
      for (int l = 1; l >= 0; l--)
      begin
         pin0(l[0], 8);
         bus(1'b0, `IOPC_OFS_INTFLAG, 32'h0, q);
         bus(1'b0, `IOPC_OFS_INTFLAG, 32'h0, q);
         chk(q & 1, l);
      end
      wr(`IOPC_OFS_INTEDGE, 32'h7FFF);
      wr(`IOPC_OFS_INTRISE, 32'h0);
      wr(`IOPC_OFS_INTFALL, 32'h1);
      for (int d = 0; d < 3; d++)
      begin
         wr(`IOPC_OFS_DBEN, d > 0);
         pin0(1'b1, 10);
         bus(1'b0, `IOPC_OFS_INTFLAG, 32'h0, q);
         pin0(1'b0, d < 2 ? 2 : 12);
         pin0(1'b1, 12);
         bus(1'b0, `IOPC_OFS_INTFLAG, 32'h0, q);
         chk(q & 1, d != 1);
      end
      extEn <= 15'h0000;
      repeat (3)
      begin
         u = $random(seed) & 32'h7FFF;
         dl = $random(seed) & 32'h7FFF & ~u;
         r1 = {$random(seed), $random(seed), $random(seed), $random(seed)};
         wr(`IOPC_OFS_PUEN, u);
         wr(`IOPC_OFS_PDEN, dl);
         wr(`IOPC_OFS_DRV0, r1[31:0]);
         wr(`IOPC_OFS_DRV1, r1[63:32]);
         bus(1'b0, `IOPC_OFS_DRV1, 32'h0, q);
         chk(q, r1[63:32] & 32'h07777777);
         for (int i = 0; i < N; i++)
            pd[i*3+:3] = nib(r1[63:0], i);
         repeat (2) @(posedge core_clk);
         chk(padPullUp, u);
         chk(padPullDown, dl);
         chk(padDrive, pd);
      end
      end_sim;
   end
endmodule
bind iopc_pin_ctrl iopc_props #(.NPIN(NPIN)) iopc_props_inst (.core_clk, .rst, .hsel,
   .htrans, .hwrite, .hready, .hreadyout, .hrdata, .padOe, .padPullUp, .padPullDown,
   .padDrive, .perIn, .adcRoute, .irq);
